// ---- core/csc_params.svh ----
// Timing counts and fixed values for the card socket control block
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

`define CSC_CLK_PERIOD_NS 40
`define CSC_T_SETUP_NS    30
`define CSC_T_STROBE_NS   250
`define CSC_T_HOLD_NS     20
`define CSC_SETUP_CYC  ((`CSC_T_SETUP_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_STROBE_CYC ((`CSC_T_STROBE_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_HOLD_CYC   ((`CSC_T_HOLD_NS + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_CNT_W      4
`define CSC_ADDR_W     26
`define CSC_DATA_W     16
`define CSC_BUF_DEPTH  2
`define CSC_CD_RST     2'h3

`endif

// ---- core/csc_pkg.sv ----
// Types shared by the card socket control block
`default_nettype none
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_OP_MEM_RD,
        CSC_OP_MEM_WR,
        CSC_OP_IO_RD,
        CSC_OP_IO_WR,
        CSC_OP_DMA_RD,
        CSC_OP_DMA_WR
    } csc_op_t;

    typedef enum logic [1:0] {
        CSC_BAT_GOOD,
        CSC_BAT_WEAK,
        CSC_BAT_DEAD
    } csc_bat_t;

    typedef enum logic [1:0] {
        CSC_ST_IDLE,
        CSC_ST_SETUP,
        CSC_ST_STROBE,
        CSC_ST_HOLD
    } csc_state_t;
endpackage : csc_pkg
`default_nettype wire

// ---- core/csc_buf.sv ----
// Small buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module csc_buf #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW-1:0]    rd_ptr_next;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction : bump

    assign in_ready  = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = push ? bump(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop ? bump(rd_ptr_reg) : rd_ptr_reg;
        count_next  = CW'(count_reg + CW'(push) - CW'(pop));
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule : csc_buf
`default_nettype wire

// ---- core/csc_ctrl.sv ----
// Control signalling for one 16-bit card socket
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module csc_ctrl #(
    parameter int ADDR_W = `CSC_ADDR_W,
    parameter int DATA_W = `CSC_DATA_W,
    parameter int DEPTH  = `CSC_BUF_DEPTH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  io_interface_mode,
    input  wire logic                  dma_enable,
    input  wire logic                  dma_req_select,
    input  wire logic                  peer_audio_in,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire csc_pkg::csc_op_t      req_op,
    input  wire logic [ADDR_W-1:0]     req_addr,
    input  wire logic [DATA_W-1:0]     req_wdata,
    input  wire logic                  req_wide,
    input  wire logic                  req_last,
    output logic                       rsp_valid,
    input  wire logic                  rsp_ready,
    output logic [DATA_W-1:0]          rsp_data,
    output logic                       rsp_ack,
    output csc_pkg::csc_bat_t          battery_state,
    output logic                       card_present,
    output logic [1:0]                 card_detect_status,
    output logic                       dma_request,
    output logic                       combined_audio_out,
    output logic                       busy,
    output logic [ADDR_W-1:0]          card_addr,
    input  wire logic [DATA_W-1:0]     card_data_in,
    output logic [DATA_W-1:0]          card_data_out,
    output logic                       card_data_oe_n,
    output logic                       even_byte_select_n,
    output logic                       odd_byte_select_n,
    output logic                       mem_read_enable_n,
    output logic                       mem_write_enable_n,
    output logic                       io_read_strobe_n,
    output logic                       io_write_strobe_n,
    output logic                       attr_select_n,
    input  wire logic                  battery_detect_one,
    input  wire logic                  battery_detect_two,
    input  wire logic                  card_detect_one_n,
    input  wire logic                  card_detect_two_n,
    input  wire logic                  input_acknowledge_n,
    input  wire logic                  card_wait_n
);
    localparam int CW = `CSC_CNT_W;
    localparam int SETUP_C = `CSC_SETUP_CYC;
    localparam int STROBE_C = `CSC_STROBE_CYC;
    localparam int HOLD_C = `CSC_HOLD_CYC;
    localparam int REACH_C = SETUP_C + 2;

    // Status path
    csc_pkg::csc_bat_t battery_reg;
    csc_pkg::csc_bat_t battery_next;
    logic              present_reg;
    logic              present_next;
    logic [1:0]        cds_reg;
    logic [1:0]        cds_next;
    logic              dreq_reg;
    logic              dreq_next;
    logic              audio_reg;
    logic              audio_next;
    logic              card_audio_in;

    // Cycle engine
    csc_pkg::csc_state_t st_reg;
    csc_pkg::csc_state_t st_next;
    logic [CW-1:0]       cnt_reg;
    logic [CW-1:0]       cnt_next;
    csc_pkg::csc_op_t    op_reg;
    csc_pkg::csc_op_t    op_next;
    logic [ADDR_W-1:0]   addr_reg;
    logic [ADDR_W-1:0]   addr_next;
    logic [DATA_W-1:0]   wdata_reg;
    logic [DATA_W-1:0]   wdata_next;
    logic                wide_reg;
    logic                wide_next;
    logic                last_reg;
    logic                last_next;
    logic                push;
    logic                buf_in_ready;

    // Card pins
    logic [7:0] pins_reg;
    logic [7:0] pins_next;
    logic       doe_n_reg;
    logic       doe_n_next;

    function automatic logic op_reads(input csc_pkg::csc_op_t op);
        op_reads = (op == csc_pkg::CSC_OP_MEM_RD) || (op == csc_pkg::CSC_OP_IO_RD) ||
                   (op == csc_pkg::CSC_OP_DMA_WR);
    endfunction : op_reads

    function automatic logic op_dma(input csc_pkg::csc_op_t op);
        op_dma = (op == csc_pkg::CSC_OP_DMA_RD) || (op == csc_pkg::CSC_OP_DMA_WR);
    endfunction : op_dma

    // Battery detect two doubles as the speaker line in I/O mode
    assign card_audio_in = battery_detect_two;

    always_comb begin
        present_next = !card_detect_one_n && !card_detect_two_n;
        cds_next     = {card_detect_two_n, card_detect_one_n};
        if (!battery_detect_one) begin
            battery_next = csc_pkg::CSC_BAT_DEAD;
        end else if (!battery_detect_two) begin
            battery_next = csc_pkg::CSC_BAT_WEAK;
        end else begin
            battery_next = csc_pkg::CSC_BAT_GOOD;
        end
        if (!dma_enable) begin
            dreq_next = 1'b0;
        end else if (dma_req_select) begin
            dreq_next = battery_detect_two;
        end else begin
            dreq_next = !input_acknowledge_n;
        end
        audio_next = (io_interface_mode && present_next && card_audio_in) ^ peer_audio_in;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            battery_reg <= csc_pkg::CSC_BAT_DEAD;
            present_reg <= 1'b0;
            cds_reg     <= `CSC_CD_RST;
            dreq_reg    <= 1'b0;
            audio_reg   <= 1'b0;
        end else begin
            battery_reg <= battery_next;
            present_reg <= present_next;
            cds_reg     <= cds_next;
            dreq_reg    <= dreq_next;
            audio_reg   <= audio_next;
        end
    end

    assign req_ready = (st_reg == csc_pkg::CSC_ST_IDLE) && present_reg && buf_in_ready;

    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        op_next    = op_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        wide_next  = wide_reg;
        last_next  = last_reg;
        push       = 1'b0;
        case (st_reg)
            csc_pkg::CSC_ST_IDLE: begin
                if (req_valid && req_ready) begin
                    st_next    = csc_pkg::CSC_ST_SETUP;
                    cnt_next   = CW'(SETUP_C - 1);
                    op_next    = req_op;
                    addr_next  = req_addr;
                    wdata_next = req_wdata;
                    wide_next  = req_wide;
                    last_next  = req_last;
                end
            end
            csc_pkg::CSC_ST_SETUP: begin
                if (cnt_reg == '0) begin
                    st_next  = csc_pkg::CSC_ST_STROBE;
                    cnt_next = CW'(STROBE_C - 1);
                end else begin
                    cnt_next = CW'(cnt_reg - 1'b1);
                end
            end
            csc_pkg::CSC_ST_STROBE: begin
                if (cnt_reg != '0) begin
                    cnt_next = CW'(cnt_reg - 1'b1);
                end else if (card_wait_n) begin
                    st_next  = csc_pkg::CSC_ST_HOLD;
                    cnt_next = CW'(HOLD_C - 1);
                    push     = op_reads(op_reg);
                end
            end
            csc_pkg::CSC_ST_HOLD: begin
                if (cnt_reg == '0) begin
                    st_next = csc_pkg::CSC_ST_IDLE;
                end else begin
                    cnt_next = CW'(cnt_reg - 1'b1);
                end
            end
            default: begin
                st_next = csc_pkg::CSC_ST_IDLE;
            end
        endcase
        if (!present_reg) begin
            st_next = csc_pkg::CSC_ST_IDLE;
            push    = 1'b0;
        end
    end

    // Pin vector: even, odd, oe, we, io_read_strobe, io_write_strobe, attr (active high here)
    always_comb begin
        logic active;
        logic strobe;
        active     = (st_next != csc_pkg::CSC_ST_IDLE) && present_next;
        strobe     = active && (st_next == csc_pkg::CSC_ST_STROBE);
        pins_next  = 8'h00;
        doe_n_next = 1'b1;
        if (active) begin
            pins_next[0] = wide_next || !addr_next[0];
            pins_next[1] = wide_next || addr_next[0];
            pins_next[6] = (op_next == csc_pkg::CSC_OP_IO_RD) || (op_next == csc_pkg::CSC_OP_IO_WR) ||
                           op_dma(op_next);
            doe_n_next   = op_reads(op_next);
        end
        if (strobe) begin
            case (op_next)
                csc_pkg::CSC_OP_MEM_RD: pins_next[2] = 1'b1;
                csc_pkg::CSC_OP_MEM_WR: pins_next[3] = 1'b1;
                csc_pkg::CSC_OP_IO_RD:  pins_next[4] = 1'b1;
                csc_pkg::CSC_OP_IO_WR:  pins_next[5] = 1'b1;
                csc_pkg::CSC_OP_DMA_WR: begin
                    pins_next[4] = 1'b1;
                    pins_next[2] = last_next;
                end
                csc_pkg::CSC_OP_DMA_RD: begin
                    pins_next[5] = 1'b1;
                    pins_next[3] = last_next;
                end
                default: pins_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg    <= csc_pkg::CSC_ST_IDLE;
            cnt_reg   <= '0;
            op_reg    <= csc_pkg::CSC_OP_MEM_RD;
            addr_reg  <= '0;
            wdata_reg <= '0;
            wide_reg  <= 1'b0;
            last_reg  <= 1'b0;
            pins_reg  <= 8'h00;
            doe_n_reg <= 1'b1;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            op_reg    <= op_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            wide_reg  <= wide_next;
            last_reg  <= last_next;
            pins_reg  <= pins_next;
            doe_n_reg <= doe_n_next;
        end
    end

    // Read data wait here so a stalled receiver loses nothing
    csc_buf #(
        .WIDTH (DATA_W + 1),
        .DEPTH (DEPTH)
    ) u_rsp_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   ({!input_acknowledge_n, card_data_in}),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  ({rsp_ack, rsp_data})
    );

    assign battery_state      = battery_reg;
    assign card_present       = present_reg;
    assign card_detect_status = cds_reg;
    assign dma_request        = dreq_reg;
    assign combined_audio_out = audio_reg;
    assign busy               = (st_reg != csc_pkg::CSC_ST_IDLE);
    assign card_addr          = addr_reg;
    assign card_data_out      = wdata_reg;
    assign card_data_oe_n     = doe_n_reg;
    assign even_byte_select_n = !pins_reg[0];
    assign odd_byte_select_n  = !pins_reg[1];
    assign mem_read_enable_n  = !pins_reg[2];
    assign mem_write_enable_n = !pins_reg[3];
    assign io_read_strobe_n   = !pins_reg[4];
    assign io_write_strobe_n  = !pins_reg[5];
    assign attr_select_n      = !pins_reg[6];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_acc(csc_pkg::csc_op_t op);
        req_valid && req_ready && req_op == op;
    endsequence

    sequence s_in_strobe(csc_pkg::csc_op_t op);
        st_reg == csc_pkg::CSC_ST_STROBE && op_reg == op && card_present;
    endsequence

    property p_bat_good;
        battery_detect_one && battery_detect_two |=> battery_state == csc_pkg::CSC_BAT_GOOD;
    endproperty
    a_bat_good: assert property (p_bat_good) else $error("good battery not decoded");

    property p_bat_weak;
        battery_detect_one && !battery_detect_two |=> battery_state == csc_pkg::CSC_BAT_WEAK;
    endproperty
    a_bat_weak: assert property (p_bat_weak) else $error("weak battery not decoded");

    property p_bat_dead;
        !battery_detect_one |=> battery_state == csc_pkg::CSC_BAT_DEAD;
    endproperty
    a_bat_dead: assert property (p_bat_dead) else $error("dead battery not decoded");

    property p_audio_io;
        io_interface_mode && !card_detect_one_n && !card_detect_two_n && !peer_audio_in
            |=> combined_audio_out == $past(battery_detect_two);
    endproperty
    a_audio_io: assert property (p_audio_io) else $error("card audio not passed");

    property p_audio_mix;
        !io_interface_mode && peer_audio_in |=> combined_audio_out;
    endproperty
    a_audio_mix: assert property (p_audio_mix) else $error("audio merge wrong");

    property p_dreq;
        dma_enable |=> dma_request == ($past(dma_req_select) ? $past(battery_detect_two)
                                                              : !$past(input_acknowledge_n));
    endproperty
    a_dreq: assert property (p_dreq) else $error("dma request source wrong");

    property p_present;
        1'b1 |=> card_present == ($past(!card_detect_one_n) && $past(!card_detect_two_n));
    endproperty
    a_present: assert property (p_present) else $error("presence wrong");

    property p_lanes;
        st_reg == csc_pkg::CSC_ST_STROBE && card_present && !wide_reg
            |-> even_byte_select_n == card_addr[0] && odd_byte_select_n == !card_addr[0];
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte lane select wrong");

    property p_io_rd;
        s_acc(csc_pkg::CSC_OP_IO_RD) |-> ##[1:REACH_C] (!io_read_strobe_n || !card_present);
    endproperty
    a_io_rd: assert property (p_io_rd) else $error("io read strobe missing");

    property p_io_wr;
        s_acc(csc_pkg::CSC_OP_IO_WR) |-> ##[1:REACH_C] (!io_write_strobe_n || !card_present);
    endproperty
    a_io_wr: assert property (p_io_wr) else $error("io write strobe missing");

    property p_dma_wr;
        s_in_strobe(csc_pkg::CSC_OP_DMA_WR)
            |-> !io_read_strobe_n && !attr_select_n && (mem_read_enable_n == !last_reg);
    endproperty
    a_dma_wr: assert property (p_dma_wr) else $error("dma write signalling wrong");

    property p_dma_rd;
        s_in_strobe(csc_pkg::CSC_OP_DMA_RD)
            |-> !io_write_strobe_n && !attr_select_n && (mem_write_enable_n == !last_reg);
    endproperty
    a_dma_rd: assert property (p_dma_rd) else $error("dma read signalling wrong");

    property p_mem_rd;
        s_in_strobe(csc_pkg::CSC_OP_MEM_RD) |-> !mem_read_enable_n && io_read_strobe_n;
    endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("output enable missing");

    property p_wait;
        st_reg == csc_pkg::CSC_ST_STROBE && cnt_reg == '0 && !card_wait_n && card_present
            |=> st_reg == csc_pkg::CSC_ST_STROBE;
    endproperty
    a_wait: assert property (p_wait) else $error("cycle ended under wait");

    property p_absent;
        !card_present |-> even_byte_select_n && odd_byte_select_n && mem_read_enable_n &&
                          mem_write_enable_n && io_read_strobe_n && io_write_strobe_n;
    endproperty
    a_absent: assert property (p_absent) else $error("card driven while absent");

    property p_excl;
        !op_dma(op_reg) |-> $onehot0({!io_read_strobe_n, !io_write_strobe_n, !mem_read_enable_n});
    endproperty
    a_excl: assert property (p_excl) else $error("strobes overlap");
endmodule : csc_ctrl
`default_nettype wire

// ---- sim/csc_card.sv ----
// Behavioural card at the far side of the socket
`timescale 1ns/10ps
`default_nettype none
module csc_card (
    input  wire logic        sys_clk,
    input  wire logic [25:0] card_addr,
    input  wire logic [15:0] card_data_out,
    input  wire logic        io_read_strobe_n,
    input  wire logic        io_write_strobe_n,
    input  wire logic        mem_read_enable_n,
    input  wire logic [3:0]  wait_len,
    input  wire logic        ack_req,
    output logic      [15:0] card_data_in,
    output logic             input_acknowledge_n,
    output logic             card_wait_n,
    output logic      [15:0] wr_data
);
    logic        rd_q   = 1'b0;
    logic        io_read_strobe_q = 1'b0;
    logic [3:0]  cnt    = 4'h0;
    logic [15:0] last_q = 16'h0;
    wire         rd     = !io_read_strobe_n || !mem_read_enable_n;
    wire         act    = rd || !io_write_strobe_n;
    // Read data held one cycle past the strobe, then driven with the inverse of the last value
    assign card_data_in = (rd || rd_q) ? (card_addr[15:0] ^ 16'h5A5A) : ~last_q;
    assign input_acknowledge_n = !(!io_read_strobe_n || io_read_strobe_q || ack_req);
    assign card_wait_n = !(act && cnt < wait_len);
    always @(posedge sys_clk) begin
        rd_q <= rd;
        io_read_strobe_q <= !io_read_strobe_n;
        last_q <= card_data_in;
        cnt <= act ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
        if (!io_write_strobe_n) wr_data <= card_data_out;
    end
endmodule : csc_card
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the card socket control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, sys_rst = 1'b1, io_interface_mode = 1'b0, dma_enable = 1'b0;
    logic dma_req_select = 1'b0, peer_audio_in = 1'b0, req_valid = 1'b0, req_wide = 1'b0;
    logic req_last = 1'b1, rsp_ready = 1'b1, battery_detect_one = 1'b1, battery_detect_two = 1'b1;
    logic card_detect_one_n = 1'b0, card_detect_two_n = 1'b0, ack_req = 1'b0;
    csc_pkg::csc_op_t  req_op = csc_pkg::CSC_OP_MEM_RD;
    csc_pkg::csc_bat_t battery_state;
    logic [25:0] req_addr = 26'h0, card_addr;
    logic [15:0] req_wdata = 16'h0, rsp_data, card_data_out, card_data_in, wr_data;
    logic [3:0]  wait_len = 4'h0;
    logic [1:0]  card_detect_status;
    logic req_ready, rsp_valid, rsp_ack, card_present, dma_request, combined_audio_out, busy;
    logic card_data_oe_n, even_byte_select_n, odd_byte_select_n, mem_read_enable_n, mem_write_enable_n;
    logic io_read_strobe_n, io_write_strobe_n, attr_select_n, input_acknowledge_n, card_wait_n;
    logic [7:0]  n [8];
    int          err_count = 0, comparisons = 0, cyc = 0;
    wire  [7:0]  lo = ~{card_data_oe_n, io_read_strobe_n, io_write_strobe_n, mem_read_enable_n, mem_write_enable_n,
                        attr_select_n, even_byte_select_n, odd_byte_select_n};
    csc_ctrl i_dut (.sys_clk, .sys_rst, .io_interface_mode, .dma_enable, .dma_req_select, .peer_audio_in,
        .req_valid, .req_ready, .req_op, .req_addr, .req_wdata, .req_wide, .req_last, .rsp_valid, .rsp_ready,
        .rsp_data, .rsp_ack, .battery_state, .card_present, .card_detect_status, .dma_request,
        .combined_audio_out, .busy, .card_addr, .card_data_in, .card_data_out, .card_data_oe_n,
        .even_byte_select_n, .odd_byte_select_n, .mem_read_enable_n, .mem_write_enable_n, .io_read_strobe_n,
        .io_write_strobe_n, .attr_select_n, .battery_detect_one, .battery_detect_two, .card_detect_one_n,
        .card_detect_two_n, .input_acknowledge_n, .card_wait_n);
    csc_card i_card (.sys_clk, .card_addr, .card_data_out, .io_read_strobe_n, .io_write_strobe_n,
        .mem_read_enable_n, .wait_len, .ack_req, .card_data_in, .input_acknowledge_n, .card_wait_n, .wr_data);
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        for (int k = 0; k < 8; k++) n[k] <= n[k] + 8'(lo[k]);
        if (lo[6:4] != 3'h0) chk(lo[6:4] == 3'h7, 0);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            close_out;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic close_out;
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic run(input int op, input logic [25:0] a, input logic w);
        int t;
        @(negedge sys_clk);
        for (int k = 0; k < 8; k++) n[k] = 8'h00;
        req_op = csc_pkg::csc_op_t'(op);
        req_addr = a;
        req_wide = w;
        req_wdata = 16'h1234 + a[15:0];
        req_valid = 1'b1;
        for (t = 0; req_ready !== 1'b1 && t < 50; t++) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (t = 0; busy !== 1'b0 && t < 50; t++) @(negedge sys_clk);
        chk(t < 50, 1);
    endtask : run
    task automatic t_status;
        for (int i = 3; i >= 0; i--) begin
            @(negedge sys_clk);
            {battery_detect_one, battery_detect_two} = i[1:0];
            {card_detect_two_n, card_detect_one_n} = i[1:0];
            @(negedge sys_clk);
            chk(battery_state, !i[1] ? csc_pkg::CSC_BAT_DEAD : i[0] ? csc_pkg::CSC_BAT_GOOD
                : csc_pkg::CSC_BAT_WEAK);
            chk(card_present, i == 0);
            chk(card_detect_status, i);
        end
        @(negedge sys_clk);
    endtask : t_status
    task automatic t_side;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            {io_interface_mode, battery_detect_two, peer_audio_in} = i[2:0];
            @(negedge sys_clk);
            chk(combined_audio_out, i[1] & i[2] ^ i[0]);
        end
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk);
            {dma_enable, dma_req_select, battery_detect_two, ack_req} = i[3:0];
            @(negedge sys_clk);
            chk(dma_request, i[3] & (i[2] ? i[1] : i[0]));
        end
        battery_detect_two = 1'b0;
        ack_req = 1'b0;
    endtask : t_side
    task automatic t_ops;
        logic [23:0] tbl;
        logic [3:0]  e;
        tbl = 24'hA54812;
        for (int op = 0; op < 6; op++) begin
            run(op, 26'(op), 1'b0);
            e = tbl[op*4 +: 4];
            for (int k = 0; k < 4; k++) chk(n[6-k], e[3-k] ? 7 : 0);
            chk(n[2], op > 1 ? 9 : 0);
            chk(n[1], op[0] ? 0 : 9);
            chk(n[0], op[0] ? 9 : 0);
            chk(n[7], (op == 1 || op == 3 || op == 4) ? 9 : 0);
            if (op == 3) chk(wr_data, 16'h1237);
        end
        req_last = 1'b0;
        run(5, 26'h1, 1'b1);
        chk(n[4], 0);
        chk(n[6], 7);
        chk({n[1], n[0]}, 16'h0909);
        run(4, 26'h2, 1'b0);
        chk(n[3], 0);
        chk(n[5], 7);
        req_last = 1'b1;
    endtask : t_ops
    task automatic t_buf;
        rsp_ready = 1'b0;
        wait_len = 4'hA;
        run(2, 26'h0A5C, 1'b1);
        chk(n[6] > 9 && n[6] < 13, 1);
        wait_len = 4'h0;
        run(0, 26'h1234, 1'b1);
        @(negedge sys_clk);
        chk(req_ready, 0);
        chk(rsp_valid, 1);
        chk(rsp_data, 16'h5006);
        chk(rsp_ack, 1);
        rsp_ready = 1'b1;
        @(negedge sys_clk);
        chk(rsp_data, 16'h486E);
        chk(rsp_ack, 0);
        @(negedge sys_clk);
        chk(rsp_valid, 0);
    endtask : t_buf
    task automatic t_abort;
        run(2, 26'h0, 1'b1);
        @(negedge sys_clk);
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        card_detect_one_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({busy, req_ready, rsp_valid, lo}, 0);
        card_detect_one_n = 1'b0;
    endtask : t_abort
    initial begin
        @(negedge sys_clk);
        chk({battery_state, card_detect_status, card_present, rsp_valid, lo}, 14'h2C00);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        t_status;
        t_side;
        t_ops;
        t_buf;
        t_abort;
        close_out;
    end
endmodule : tb
`default_nettype wire
